// >>> pkg/scrb_pkg.sv
// scrb_pkg: constants for the sensor configuration register bank.
// assumes a 25 MHz core clock; times are in milliseconds.
package scrb_pkg;

    // ************************************************************
    // clock and timing
    // ************************************************************
    localparam int CLK_HZ         = 25_000_000;
    localparam int CYC_PER_MS     = CLK_HZ / 1000;
    localparam int CONV_MS_9      = 25;
    localparam int CONV_MS_10     = 50;
    localparam int CONV_MS_11     = 100;
    localparam int CONV_MS_12     = 200;
    localparam int PROG_MS        = 20;
    localparam int CONV_CYC_9     = CONV_MS_9 * CYC_PER_MS;
    localparam int CONV_CYC_10    = CONV_MS_10 * CYC_PER_MS;
    localparam int CONV_CYC_11    = CONV_MS_11 * CYC_PER_MS;
    localparam int CONV_CYC_12    = CONV_MS_12 * CYC_PER_MS;
    localparam int PROG_CYC       = PROG_MS * CYC_PER_MS;
    localparam int CNT_W          = 23;

    // ************************************************************
    // field positions in the operating configuration
    // ************************************************************
    localparam int CFG_OS_BIT     = 15;
    localparam int CFG_RES_LSB    = 13;
    localparam int CFG_FQ_LSB     = 11;
    localparam int CFG_POL_BIT    = 10;
    localparam int CFG_MODE_BIT   = 9;
    localparam int CFG_SD_BIT     = 8;
    localparam int CFG_BUSY_BIT   = 0;
    localparam int NV_HI_LSB      = 8;

    // ************************************************************
    // reset and factory values
    // ************************************************************
    localparam logic [6:0]  CFG_RESET     = 7'h00;
    localparam logic [15:0] NV_FACTORY    = 16'h0000;
    localparam logic [15:0] NV_WR_MASK    = 16'h7f06;
    localparam logic [3:0]  RES_WIDTH_MIN = 4'h9;
    localparam logic [3:0]  LSB_W_9       = 4'h8;
    localparam logic [3:0]  LSB_W_10      = 4'h4;
    localparam logic [3:0]  LSB_W_11      = 4'h2;
    localparam logic [3:0]  LSB_W_12      = 4'h1;
    localparam logic [2:0]  FQ_NEED_0     = 3'h1;
    localparam logic [2:0]  FQ_NEED_1     = 3'h2;
    localparam logic [2:0]  FQ_NEED_2     = 3'h4;
    localparam logic [2:0]  FQ_NEED_3     = 3'h6;

    // ************************************************************
    // state machines
    // ************************************************************
    typedef enum logic [1:0] {CV_IDLE = 2'b01, CV_RUN = 2'b10} scrb_conv_e;
    typedef enum logic [1:0] {PG_IDLE = 2'b01, PG_BUSY = 2'b10} scrb_prog_e;

endpackage

// >>> logic/scrb_top.sv
// scrb_top: operating and stored-default configuration of the sensor,
// conversion pacing, fault queue and alert pin drive.
// assumes a serial protocol engine on the same clock delivers decoded
// byte strobes, and limit-compare logic reports each conversion's fault.
`timescale 1ns/100ps

module scrb_top
    import scrb_pkg::*;
#(
    parameter int P_CONV_CYC_9  = CONV_CYC_9,
    parameter int P_CONV_CYC_10 = CONV_CYC_10,
    parameter int P_CONV_CYC_11 = CONV_CYC_11,
    parameter int P_CONV_CYC_12 = CONV_CYC_12,
    parameter int P_PROG_CYC    = PROG_CYC
)
(
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    input  wire logic        i_nv_factory,
    input  wire logic        i_cfg_wr,
    input  wire logic        i_cfg_first,
    input  wire logic [7:0]  i_cfg_byte,
    input  wire logic        i_nv_byte,
    input  wire logic [7:0]  i_nv_data,
    input  wire logic        i_bus_stop,
    input  wire logic        i_bus_rstart,
    input  wire logic        i_copy_nv_to_v,
    input  wire logic        i_copy_v_to_nv,
    input  wire logic        i_fault_valid,
    input  wire logic        i_fault,
    input  wire logic        i_alarm_ack,
    output logic [15:0]      o_cfg_read,
    output logic [15:0]      o_nv_read,
    output logic             o_nv_busy,
    output logic [3:0]       o_result_width,
    output logic [3:0]       o_lsb_weight,
    output logic             o_conv_done,
    output logic             o_converting,
    output logic             o_alert
);

    // ************************************************************
    // storage
    // ************************************************************
    logic [6:0]       cfg;
    logic [15:0]      nv;
    logic [15:0]      nv_stage;
    logic [15:0]      nv_pend;
    logic [1:0]       nv_count;
    logic             load_pending;
    logic             oneshot_pend;
    scrb_conv_e       conv_state;
    scrb_prog_e       prog_state;
    logic [CNT_W-1:0] conv_cnt;
    logic [CNT_W-1:0] prog_cnt;
    logic [1:0]       conv_res;
    logic [2:0]       fault_cnt;
    logic             alarm;

    logic             busy;
    logic [1:0]       res_sel;
    logic [1:0]       fq_sel;
    logic             alarm_sense_level;
    logic             mode;
    logic             sd;
    logic [CNT_W-1:0] conv_last;
    logic [2:0]       fq_need;
    logic             conv_end;
    logic             prog_end;
    logic             prog_go;
    logic [15:0]      prog_data;
    logic             fault_hit;

    assign busy     = (prog_state == PG_BUSY);
    assign res_sel  = cfg[CFG_RES_LSB-NV_HI_LSB +: 2];
    assign fq_sel   = cfg[CFG_FQ_LSB-NV_HI_LSB +: 2];
    assign alarm_sense_level      = cfg[CFG_POL_BIT-NV_HI_LSB];
    assign mode     = cfg[CFG_MODE_BIT-NV_HI_LSB];
    assign sd       = cfg[CFG_SD_BIT-NV_HI_LSB];
    assign conv_end = (conv_state == CV_RUN) && (conv_cnt == conv_last);
    assign prog_end = busy && (prog_cnt == CNT_W'(P_PROG_CYC - 1));

    always_comb
    begin
        case (conv_res)
            2'b00:   conv_last = CNT_W'(P_CONV_CYC_9 - 1);
            2'b01:   conv_last = CNT_W'(P_CONV_CYC_10 - 1);
            2'b10:   conv_last = CNT_W'(P_CONV_CYC_11 - 1);
            default: conv_last = CNT_W'(P_CONV_CYC_12 - 1);
        endcase
        case (fq_sel)
            2'b00:   fq_need = FQ_NEED_0;
            2'b01:   fq_need = FQ_NEED_1;
            2'b10:   fq_need = FQ_NEED_2;
            default: fq_need = FQ_NEED_3;
        endcase
    end

    // ************************************************************
    // operating configuration
    // ************************************************************
    // the reset cannot take the stored value itself, so it arms a
    // one-cycle load that runs on the first edge after release
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            load_pending <= 1'b1;
            cfg          <= CFG_RESET;
        end
        else if (load_pending)
        begin
            load_pending <= 1'b0;
            cfg          <= nv[NV_HI_LSB +: 7];
        end
        else if (i_copy_nv_to_v && !busy)
        begin
            cfg <= nv[NV_HI_LSB +: 7];
        end
        else if (i_cfg_wr && i_cfg_first)
        begin
            cfg <= i_cfg_byte[6:0];
        end
    end

    // one-shot is only honoured while parked in shutdown
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            oneshot_pend <= 1'b0;
        else if (i_cfg_wr && i_cfg_first && i_cfg_byte[7] && !load_pending
                 && sd && conv_state == CV_IDLE)
            oneshot_pend <= 1'b1;
        else if (conv_end)
            oneshot_pend <= 1'b0;
    end

    // ************************************************************
    // conversion pacing
    // ************************************************************
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            conv_state <= CV_IDLE;
            conv_cnt   <= '0;
            conv_res   <= 2'b00;
        end
        else
        begin
            case (conv_state)
                CV_IDLE:
                begin
                    if (!load_pending && (!sd || oneshot_pend))
                    begin
                        conv_state <= CV_RUN;
                        conv_cnt   <= '0;
                        conv_res   <= res_sel;
                    end
                end
                CV_RUN:
                begin
                    if (conv_end)
                    begin
                        conv_cnt <= '0;
                        conv_res <= res_sel;
                        if (sd)
                            conv_state <= CV_IDLE;
                        else
                            conv_state <= CV_RUN;
                    end
                    else
                    begin
                        conv_cnt <= conv_cnt + 1'b1;
                    end
                end
                default:
                begin
                    conv_state <= CV_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_conv_done    <= 1'b0;
            o_converting   <= 1'b0;
            o_result_width <= RES_WIDTH_MIN;
            o_lsb_weight   <= LSB_W_9;
        end
        else
        begin
            o_conv_done    <= conv_end;
            o_converting   <= (conv_state == CV_RUN);
            o_result_width <= RES_WIDTH_MIN + {2'b00, conv_res};
            case (conv_res)
                2'b00:   o_lsb_weight <= LSB_W_9;
                2'b01:   o_lsb_weight <= LSB_W_10;
                2'b10:   o_lsb_weight <= LSB_W_11;
                default: o_lsb_weight <= LSB_W_12;
            endcase
        end
    end

    // ************************************************************
    // fault queue and alert
    // ************************************************************
    assign fault_hit = i_fault_valid && i_fault && ((fault_cnt + 3'h1) >= fq_need);

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            fault_cnt <= 3'h0;
        else if (i_fault_valid && !i_fault)
            fault_cnt <= 3'h0;
        else if (i_fault_valid && fault_cnt < FQ_NEED_3)
            fault_cnt <= fault_cnt + 3'h1;
    end

    // interrupt mode: a new hit wins over a same-cycle acknowledge
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            alarm <= 1'b0;
        else if (!mode)
        begin
            if (i_fault_valid)
                alarm <= fault_hit;
        end
        else if (fault_hit && (fault_cnt + 3'h1) == fq_need)
            alarm <= 1'b1;
        else if (i_alarm_ack)
            alarm <= 1'b0;
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            o_alert <= 1'b1;
        else
            o_alert <= alarm_sense_level ? alarm : !alarm;
    end

    // ************************************************************
    // stored defaults and program cycle
    // ************************************************************
    // staged bytes only count once both arrive; a restart drops them
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            nv_count <= 2'd0;
            nv_stage <= 16'h0000;
        end
        else if (i_bus_stop || i_bus_rstart)
            nv_count <= 2'd0;
        else if (i_nv_byte && !busy && nv_count != 2'd2)
        begin
            nv_count <= nv_count + 2'd1;
            if (nv_count == 2'd0)
                nv_stage[15:8] <= i_nv_data;
            else
                nv_stage[7:0] <= i_nv_data;
        end
    end

    always_comb
    begin
        prog_go   = 1'b0;
        prog_data = nv;
        if (!busy && i_bus_stop && nv_count == 2'd2)
        begin
            prog_go   = 1'b1;
            prog_data = nv_stage & NV_WR_MASK;
        end
        else if (!busy && i_copy_v_to_nv)
        begin
            prog_go   = 1'b1;
            prog_data = {1'b0, cfg, nv[7:0]} & NV_WR_MASK;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            prog_state <= PG_IDLE;
            prog_cnt   <= '0;
            nv_pend    <= 16'h0000;
        end
        else
        begin
            case (prog_state)
                PG_IDLE:
                begin
                    prog_cnt <= '0;
                    if (prog_go)
                    begin
                        prog_state <= PG_BUSY;
                        nv_pend    <= prog_data;
                    end
                end
                PG_BUSY:
                begin
                    prog_cnt <= prog_cnt + 1'b1;
                    if (prog_end)
                        prog_state <= PG_IDLE;
                end
                default:
                begin
                    prog_state <= PG_IDLE;
                end
            endcase
        end
    end

    // the cells keep their value through i_rst; only the factory
    // restore clears them
    always_ff @(posedge i_clock or posedge i_nv_factory)
    begin
        if (i_nv_factory)
            nv <= NV_FACTORY;
        else if (prog_end)
            nv <= nv_pend;
    end

    // ************************************************************
    // read views
    // ************************************************************
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_cfg_read <= 16'h0000;
            o_nv_read  <= 16'h0000;
            o_nv_busy  <= 1'b0;
        end
        else
        begin
            o_cfg_read <= {1'b0, cfg, 7'h00, busy};
            o_nv_read  <= nv & NV_WR_MASK;
            o_nv_busy  <= busy;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    sequence s_prog_start;
        !busy ##1 busy;
    endsequence

    sequence s_prog_run;
        busy [*8];
    endsequence

    res_width_a: assert property (o_conv_done |-> (o_result_width == 4'h9) == (o_lsb_weight == LSB_W_9)) else $error("width and lsb disagree");
    conv_pace_a: assert property (conv_end |=> o_conv_done && conv_cnt == '0) else $error("conversion end not flagged");
    reset_load_a: assert property ($fell(load_pending) |-> cfg == $past(nv[NV_HI_LSB +: 7])) else $error("reset load wrong");
    queue_hit_a: assert property ($rose(alarm) |-> $past(fault_hit)) else $error("alarm without full queue");
    pin_level_a: assert property (##1 o_alert == ($past(alarm_sense_level) ? $past(alarm) : !$past(alarm))) else $error("alert level wrong");
    cmp_clear_a: assert property (i_fault_valid && !i_fault && !mode |=> !alarm) else $error("comparator alarm stuck");
    shut_finish_a: assert property (conv_end && sd |=> conv_state == CV_IDLE) else $error("shutdown not entered");
    run_cont_a: assert property (conv_end && !sd |=> conv_state == CV_RUN) else $error("continuous run stopped");
    wake_up_a: assert property (conv_state == CV_IDLE && !sd && !load_pending |=> conv_state == CV_RUN) else $error("no resume");
    busy_view_a: assert property (s_prog_start |-> ##1 o_cfg_read[0] && o_nv_busy) else $error("busy not shown");
    nv_hold_a: assert property (busy && !prog_end |=> $stable(nv)) else $error("stored value moved while busy");
    copy_ign_a: assert property (busy && i_copy_nv_to_v && !i_cfg_wr && !load_pending |=> $stable(cfg)) else $error("copy while busy");
    first_byte_a: assert property (i_cfg_wr && !i_cfg_first && !i_copy_nv_to_v && !load_pending |=> $stable(cfg)) else $error("extra byte taken");
    stop_prog_a: assert property (i_bus_stop && nv_count == 2'd2 && !busy |=> s_prog_run) else $error("program not started");
    rsvd_zero_a: assert property (o_cfg_read[7:1] == 7'h00 && o_cfg_read[15] == 1'b0) else $error("reserved bits set");

endmodule

// >>> verif/scrb_host.sv
// scrb_host: behavioural two-wire host that drives the decoded byte strobes
// assumes the bank samples every strobe on the rising edge of i_clock
`timescale 1ns/100ps
module scrb_host
(
    input  wire logic        i_clock,
    input  wire logic        i_nv_busy,
    input  wire logic [15:0] i_nv_read,
    output logic             o_cfg_wr,
    output logic             o_cfg_first,
    output logic [7:0]       o_cfg_byte,
    output logic             o_nv_byte,
    output logic [7:0]       o_nv_data,
    output logic             o_bus_stop,
    output logic             o_bus_rstart,
    output logic             o_copy_nv_to_v,
    output logic             o_copy_v_to_nv
);
    initial
    begin
        {o_cfg_wr, o_cfg_first, o_nv_byte, o_bus_stop, o_bus_rstart} = 5'h00;
        {o_copy_nv_to_v, o_copy_v_to_nv, o_cfg_byte, o_nv_data} = 18'h00000;
    end

    // ******************************
    // transfers, one strobe cycle each
    // ******************************
    // idle data lines carry the inverse of the last byte, never a stale copy
    task automatic cfg_write(input logic first, input logic [7:0] b);
        @(negedge i_clock);
        o_cfg_wr    = 1'b1;
        o_cfg_first = first;
        o_cfg_byte  = b;
        @(negedge i_clock);
        o_cfg_wr    = 1'b0;
        o_cfg_first = ~first;
        o_cfg_byte  = ~b;
    endtask

    task automatic nv_write(input int n, input logic [15:0] d, input logic abort);
        for (int i = 0; i < n; i++)
        begin
            @(negedge i_clock);
            o_nv_byte = 1'b1;
            o_nv_data = (i == 0) ? d[15:8] : ((i == 1) ? d[7:0] : ~d[7:0]);
            @(negedge i_clock);
            o_nv_byte = 1'b0;
            o_nv_data = ~o_nv_data;
        end
        @(negedge i_clock);
        o_bus_rstart = abort;
        o_bus_stop   = ~abort;
        @(negedge i_clock);
        o_bus_rstart = 1'b0;
        o_bus_stop   = 1'b0;
    endtask

    task automatic copy(input logic to_v);
        @(negedge i_clock);
        o_copy_nv_to_v = to_v;
        o_copy_v_to_nv = ~to_v;
        @(negedge i_clock);
        o_copy_nv_to_v = 1'b0;
        o_copy_v_to_nv = 1'b0;
    endtask

    // the stored copy is only read once busy has dropped
    task automatic read_nv(output logic [15:0] v);
        int n;
        n = 0;
        repeat (2) @(negedge i_clock);
        while (i_nv_busy !== 1'b0 && n < 1000)
        begin
            @(negedge i_clock);
            n++;
        end
        @(negedge i_clock);
        v = i_nv_read;
    endtask
endmodule

// >>> verif/test_sensor_config_register_bank.sv
// test_sensor_config_register_bank: self-checking bench with a reference model
// assumes shortened conversion and program counts set at the instance below
`timescale 1ns/100ps
module test_sensor_config_register_bank
    import scrb_pkg::*;
;
    logic        i_clock = 1'b0;
    logic        i_rst = 1'b1;
    logic        i_nv_factory = 1'b1;
    logic        i_fault_valid = 1'b0;
    logic        i_fault = 1'b0;
    logic        i_alarm_ack = 1'b0;
    logic        cfg_wr, cfg_first, nv_byte, bus_stop, bus_rstart, cp_nv_v, cp_v_nv;
    logic [7:0]  cfg_byte, nv_data;
    logic [15:0] o_cfg_read, o_nv_read;
    logic [3:0]  o_result_width, o_lsb_weight;
    logic        o_nv_busy, o_conv_done, o_converting, o_alert;
    int          n_errors = 0;
    int          check_count = 0;
    int          seed = 78606;
    int          m_cnt = 0;
    logic        m_alarm = 1'b0;
    logic [6:0]  m_cfg = 7'h00;
    logic [15:0] m_stored = 16'h0000;
    int          need_tab[4] = '{1, 2, 4, 6};
    int          per_tab[4] = '{20, 30, 40, 50};

    always #20 i_clock = ~i_clock;

    scrb_top #(.P_CONV_CYC_9(20), .P_CONV_CYC_10(30), .P_CONV_CYC_11(40),
               .P_CONV_CYC_12(50), .P_PROG_CYC(16)) scrb_top_i (
        .i_clock(i_clock), .i_rst(i_rst), .i_nv_factory(i_nv_factory),
        .i_cfg_wr(cfg_wr), .i_cfg_first(cfg_first), .i_cfg_byte(cfg_byte),
        .i_nv_byte(nv_byte), .i_nv_data(nv_data), .i_bus_stop(bus_stop),
        .i_bus_rstart(bus_rstart), .i_copy_nv_to_v(cp_nv_v), .i_copy_v_to_nv(cp_v_nv),
        .i_fault_valid(i_fault_valid), .i_fault(i_fault), .i_alarm_ack(i_alarm_ack),
        .o_cfg_read(o_cfg_read), .o_nv_read(o_nv_read), .o_nv_busy(o_nv_busy),
        .o_result_width(o_result_width), .o_lsb_weight(o_lsb_weight),
        .o_conv_done(o_conv_done), .o_converting(o_converting), .o_alert(o_alert));

    scrb_host scrb_host_i (
        .i_clock(i_clock), .i_nv_busy(o_nv_busy), .i_nv_read(o_nv_read),
        .o_cfg_wr(cfg_wr), .o_cfg_first(cfg_first), .o_cfg_byte(cfg_byte),
        .o_nv_byte(nv_byte), .o_nv_data(nv_data), .o_bus_stop(bus_stop),
        .o_bus_rstart(bus_rstart), .o_copy_nv_to_v(cp_nv_v), .o_copy_v_to_nv(cp_v_nv));

    // ******************************
    // checking and model tasks
    // ******************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic do_reset();
        i_rst = 1'b1;
        repeat (16) @(negedge i_clock);
        i_rst = 1'b0;
        repeat (3) @(negedge i_clock);
    endtask

    task automatic cfgw(input logic [7:0] b);
        scrb_host_i.cfg_write(1'b1, b);
        m_cfg = b[6:0];
        repeat (2) @(negedge i_clock);
        chk("cfg_read", {1'b0, m_cfg, 7'h00, 1'b0}, o_cfg_read);
    endtask

    // a missing pulse shows as the full 200-cycle wait
    task automatic wait_done(output int c);
        c = 0;
        while (o_conv_done !== 1'b1 && c < 200)
        begin
            @(negedge i_clock);
            c++;
        end
        @(negedge i_clock);
    endtask

    task automatic flt(input logic f, input logic ack);
        @(negedge i_clock);
        i_fault_valid = ~ack;
        i_alarm_ack   = ack;
        i_fault       = f;
        if (ack && m_cfg[1])
            m_alarm = 1'b0;
        else if (!ack && f)
        begin
            m_cnt++;
            if (m_cfg[1])
                m_alarm = m_alarm | (m_cnt == need_tab[m_cfg[4:3]]);
            else
                m_alarm = (m_cnt >= need_tab[m_cfg[4:3]]);
        end
        else if (!ack)
        begin
            m_cnt = 0;
            m_alarm = m_alarm & m_cfg[1];
        end
        @(negedge i_clock);
        i_fault_valid = 1'b0;
        // acknowledge means nothing in comparator mode, so it is noise there
        i_alarm_ack   = !m_cfg[1] && 1'($random(seed));
        i_fault = 1'($random(seed));
        repeat (2) @(negedge i_clock);
        chk("alert", m_alarm ? m_cfg[2] : !m_cfg[2], o_alert);
    endtask

    // ******************************
    // main sequence
    // ******************************
    initial
    begin
        int          c;
        logic [15:0] d;
        logic [15:0] v;
        repeat (4) @(negedge i_clock);
        i_nv_factory = 1'b0;
        do_reset();
        chk("cfg_read", 32'h0, o_cfg_read);
        chk("alert", 32'h1, o_alert);
        $display("test reset done");
        for (int r = 0; r < 4; r++)
        begin
            cfgw({1'b0, 2'(r), 5'h00});
            wait_done(c);
            wait_done(c);
            chk("period", per_tab[r] - 1, c);
            chk("width", 9 + r, o_result_width);
            chk("lsb", 8 >> r, o_lsb_weight);
        end
        $display("test resolution done");
        cfgw(8'h01);
        wait_done(c);
        chk("finish run", 32'h1, c < per_tab[3]);
        wait_done(c);
        chk("idle", 200, c);
        scrb_host_i.cfg_write(1'b1, 8'h81);
        wait_done(c);
        chk("one shot", 32'h1, c < 200);
        wait_done(c);
        chk("idle", 200, c);
        cfgw(8'h00);
        chk("converting", 32'h1, o_converting);
        wait_done(c);
        wait_done(c);
        chk("period", per_tab[0] - 1, c);
        $display("test shutdown done");
        for (int m = 0; m < 2; m++)
            for (int q = 0; q < 4; q++)
            begin
                cfgw({3'b000, 2'(q), 1'($random(seed)), 1'(m), 1'b1});
                flt(1'b0, 1'b0);
                flt(1'b0, 1'b1);
                for (int k = 0; k <= need_tab[q]; k++)
                    flt(1'b1, 1'b0);
                flt(1'b0, 1'b0);
                flt(1'b0, 1'b1);
            end
        $display("test alarm done");
        for (int p = 0; p < 2; p++)
        begin
            d = 16'($random(seed));
            d[8] = 1'(p);
            scrb_host_i.nv_write(2, d, 1'b0);
            repeat (2) @(negedge i_clock);
            chk("busy", 32'h1, o_nv_busy);
            chk("busy bit", 32'h1, o_cfg_read[0]);
            scrb_host_i.nv_write(2, ~d, 1'b0);
            scrb_host_i.copy(1'b1);
            scrb_host_i.copy(1'b0);
            chk("cfg_read", {1'b0, m_cfg, 7'h00, 1'b1}, o_cfg_read);
            scrb_host_i.read_nv(v);
            m_stored = d & NV_WR_MASK;
            chk("stored", m_stored, v);
            do_reset();
            m_cfg = m_stored[14:8];
            chk("cfg_read", {1'b0, m_cfg, 7'h00, 1'b0}, o_cfg_read);
            chk("stored", m_stored, o_nv_read);
            chk("converting", p == 0, o_converting);
        end
        $display("test stored done");
        scrb_host_i.nv_write(1, ~m_stored, 1'b0);
        scrb_host_i.nv_write(2, ~m_stored, 1'b1);
        repeat (2) @(negedge i_clock);
        chk("busy", 32'h0, o_nv_busy);
        chk("stored", m_stored, o_nv_read);
        d = 16'($random(seed));
        scrb_host_i.nv_write(3, d, 1'b0);
        scrb_host_i.read_nv(v);
        m_stored = d & NV_WR_MASK;
        chk("stored", m_stored, v);
        scrb_host_i.cfg_write(1'b0, 8'h7f);
        repeat (2) @(negedge i_clock);
        chk("cfg_read", {1'b0, m_cfg, 7'h00, 1'b0}, o_cfg_read);
        cfgw(~m_stored[15:8] & 8'h7f);
        scrb_host_i.copy(1'b1);
        m_cfg = m_stored[14:8];
        repeat (2) @(negedge i_clock);
        chk("cfg_read", {1'b0, m_cfg, 7'h00, 1'b0}, o_cfg_read);
        cfgw(~m_stored[15:8] & 8'h7f);
        scrb_host_i.copy(1'b0);
        scrb_host_i.read_nv(v);
        m_stored = {1'b0, m_cfg, m_stored[7:0]} & NV_WR_MASK;
        chk("stored", m_stored, v);
        @(negedge i_clock);
        i_nv_factory = 1'b1;
        @(negedge i_clock);
        i_nv_factory = 1'b0;
        repeat (2) @(negedge i_clock);
        chk("factory", NV_FACTORY & NV_WR_MASK, o_nv_read);
        $display("test partial writes and copy done");
        give_verdict();
    end

    // ******************************
    // watchdog
    // ******************************
    initial
    begin
        #(40 * 30000);
        n_errors++;
        give_verdict();
    end
endmodule
